//--- ebacc_core.sv
// byte-lane steering, transfer splitting and memory chip-select decode
// assumes requests on the bus clock; strap and read data pins are asynchronous
// Notes on behaviour
// [R1] config bit 6 picks area 0 (clear) or area 2 (set) for decode
// [R2] two-bit density field: 32, 64, 128 or 256 megabit attached part
// [R3] config bits 3..0 give address bits 25..22 of region start
// [R4] eight chip-select outputs, each with its own identical config register
// [R5] byte order taken from strap pin after reset: low big, high little
// [R6] big endian offset 0 is most significant byte; little endian least
// [R7] legal widths: ordinary 8/16/32, DRAM 16/32, SDRAM 32, card 8/16
// [R8] access wider than device splits into consecutive device-width transfers
// [R9] 32-bit big endian lanes: offset 0 on top lane, down to offset 3
// [R10] 16-bit big endian: even offset upper lane; longword high half first
// [R11] 8-bit big endian: lowest lane, most significant byte first
// [R12] 32-bit little endian lanes: offset 0 on bottom lane, up to offset 3
// [R13] 16-bit little endian: even offset lower lane; longword low half first
// [R14] 8-bit little endian: lowest lane, least significant byte first
// [R15] strobes act by memory type; lanes without data stay deasserted
// [R16] read bytes from split transfers reassembled into datum order
//
// Decided for this implementation: the Avalon-MM interface to the registers and the placing of the registers.
module ebacc_core #(
	parameter int NUM_SELECTS = ebacc_pkg::NUM_SELECTS
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] avAddress,
	input wire logic avRead,
	input wire logic avWrite,
	input wire logic [31:0] avWritedata,
	input wire logic [3:0] avByteenable,
	output logic [31:0] avReaddata,
	output logic avWaitrequest,
	input wire logic intValid,
	input wire ebacc_pkg::ebacc_req_t intReq,
	output logic intReady,
	output logic intDone,
	output logic [31:0] intRData,
	input wire logic byteOrderStrap,
	output ebacc_pkg::ebacc_ext_t extBus,
	input wire logic [31:0] extDataIn,
	output logic [3:0] laneWriteStrobeN,
	output logic [3:0] laneColumnStrobeN,
	output logic [3:0] laneDataMask,
	output logic [NUM_SELECTS-1:0] memoryChipSelectOutN
);

	generate
		if (NUM_SELECTS < 1 || NUM_SELECTS > 8)
		begin : g_bad_selects
			$error("NUM_SELECTS must be 1 to 8");
		end
	endgenerate

	typedef enum {ST_IDLE, ST_XFER, ST_FINISH} ebacc_state_t;

	ebacc_state_t state;
	logic strapMeta;
	logic strapSync;
	logic [1:0] settleCnt;
	logic strapTaken;
	logic littleEndian;
	logic [31:0] dinMeta;
	logic [31:0] dinSync;
	logic [ebacc_pkg::CFG_WIDTH-1:0] selCfg [NUM_SELECTS];
	logic [1:0] ctrlWidth;
	logic [1:0] ctrlType;
	logic [2:0] cfgIdx;
	logic cfgHit;
	ebacc_pkg::ebacc_req_t curReq;
	logic [1:0] curWidth;
	logic [1:0] curType;
	logic curLittle;
	logic [1:0] xferIdx;
	logic [1:0] lastXfer;
	logic [7:0] waitCnt;
	logic [3:0] laneValidQ;
	logic [1:0] laneSigQ [4];
	logic [7:0] rdAsm [4];
	logic accept;
	// lane plan for the transfer about to be driven
	logic [31:0] planAddr;
	logic [1:0] planSize;
	logic [1:0] planWidth;
	logic planLittle;
	logic [1:0] planK;
	logic [2:0] planW;
	logic [2:0] planS;
	logic [2:0] planN;
	logic [1:0] planTbo;
	logic [3:0] next_laneValid;
	logic [1:0] next_laneSig [4];
	logic [31:0] next_laneData;
	logic [NUM_SELECTS-1:0] next_selN;

	function automatic logic [2:0] size_bytes(input logic [1:0] code);
		size_bytes = (code == ebacc_pkg::SIZE_LONG) ? 3'h4 : (code == ebacc_pkg::SIZE_WORD) ? 3'h2 : 3'h1;
	endfunction

	function automatic logic [2:0] width_bytes(input logic [1:0] code);
		width_bytes = (code == ebacc_pkg::WID_32) ? 3'h4 : (code == ebacc_pkg::WID_16) ? 3'h2 : 3'h1;
	endfunction

	function automatic logic width_legal(input logic [1:0] memType, input logic [1:0] width);
		unique case (memType)
			ebacc_pkg::MEM_ORDINARY: width_legal = (width != 2'h3);
			ebacc_pkg::MEM_DRAM: width_legal = (width == ebacc_pkg::WID_16) || (width == ebacc_pkg::WID_32);
			ebacc_pkg::MEM_SDRAM: width_legal = (width == ebacc_pkg::WID_32);
			ebacc_pkg::MEM_CARD: width_legal = (width == ebacc_pkg::WID_8) || (width == ebacc_pkg::WID_16);
		endcase
	endfunction

	// strap and read data synchronisers
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			strapMeta <= 1'b0;
			strapSync <= 1'b0;
			dinMeta <= 32'h00000000;
			dinSync <= 32'h00000000;
		end
		else
		begin
			strapMeta <= byteOrderStrap;
			strapSync <= strapMeta;
			dinMeta <= extDataIn;
			dinSync <= dinMeta;
		end
	end

	// byte order caught once after reset release
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			settleCnt <= 2'h0;
			strapTaken <= 1'b0;
			littleEndian <= 1'b0;
		end
		else if (!strapTaken)
		begin
			if (settleCnt == ebacc_pkg::STRAP_SETTLE - 2'h1)
			begin
				littleEndian <= strapSync; // [R5]
				strapTaken <= 1'b1;
			end
			else
				settleCnt <= settleCnt + 2'h1;
		end
	end

	// register bus: one wait cycle, then completion
	assign cfgIdx = avAddress[4:2];
	assign cfgHit = (avAddress[7:5] == ebacc_pkg::CFG_BASE_ADDR[7:5]) && (32'(cfgIdx) < NUM_SELECTS);

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			avWaitrequest <= 1'b1;
		else if ((avRead || avWrite) && avWaitrequest)
			avWaitrequest <= 1'b0;
		else
			avWaitrequest <= 1'b1;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			avReaddata <= 32'h00000000;
		else if (avRead && avWaitrequest)
		begin
			if (cfgHit)
				avReaddata <= {25'h0000000, selCfg[cfgIdx]};
			else if ({avAddress[7:2], 2'h0} == ebacc_pkg::CTRL_ADDR)
				avReaddata <= {28'h0000000, ctrlType, ctrlWidth};
			else if ({avAddress[7:2], 2'h0} == ebacc_pkg::STATUS_ADDR)
				avReaddata <= {29'h00000000, state != ST_IDLE, strapTaken, littleEndian};
			else
				avReaddata <= 32'h00000000;
		end
	end

	generate
		for (genvar gi = 0; gi < NUM_SELECTS; gi++)
		begin : g_cfg
			always_ff @(posedge clk or negedge resetn)
			begin
				if (!resetn)
					selCfg[gi] <= ebacc_pkg::CFG_RESET;
				else if (avWrite && !avWaitrequest && cfgHit && cfgIdx == 3'(gi) && avByteenable[0])
					selCfg[gi] <= avWritedata[ebacc_pkg::CFG_WIDTH-1:0]; // [R4]
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ctrlWidth <= ebacc_pkg::CTRL_WIDTH_RESET;
			ctrlType <= ebacc_pkg::CTRL_TYPE_RESET;
		end
		else if (avWrite && !avWaitrequest && {avAddress[7:2], 2'h0} == ebacc_pkg::CTRL_ADDR && avByteenable[0])
		begin
			// illegal pairings are dropped whole
			if (width_legal(avWritedata[ebacc_pkg::CTRL_TYPE_LO +: 2], avWritedata[ebacc_pkg::CTRL_WIDTH_LO +: 2]))
			begin
				ctrlWidth <= avWritedata[ebacc_pkg::CTRL_WIDTH_LO +: 2]; // [R7]
				ctrlType <= avWritedata[ebacc_pkg::CTRL_TYPE_LO +: 2];
			end
		end
	end

	// chip-select decode for the incoming request
	generate
		for (genvar gs = 0; gs < NUM_SELECTS; gs++)
		begin : g_sel
			logic [2:0] area;
			logic [4:0] diff;
			logic [3:0] units;
			assign area = selCfg[gs][ebacc_pkg::CFG_AREA_BIT] ? ebacc_pkg::AREA_2 : ebacc_pkg::AREA_0; // [R1]
			assign units = 4'h1 << selCfg[gs][ebacc_pkg::CFG_DENS_LO +: 2]; // [R2]
			assign diff = {1'b0, intReq.addr[25:22]} - {1'b0, selCfg[gs][ebacc_pkg::CFG_START_LO +: 4]}; // [R3]
			assign next_selN[gs] = !((intReq.addr[28:26] == area) && !diff[4] && (diff[3:0] < units));
		end
	endgenerate

	// plan: first transfer from the request, later ones from the held access
	assign accept = intValid && intReady;
	assign planAddr = (state == ST_IDLE) ? intReq.addr : curReq.addr;
	assign planSize = (state == ST_IDLE) ? intReq.size : curReq.size;
	assign planWidth = (state == ST_IDLE) ? ctrlWidth : curWidth;
	assign planLittle = (state == ST_IDLE) ? littleEndian : curLittle;
	assign planK = (state == ST_IDLE) ? 2'h0 : xferIdx + 2'h1;
	assign planW = width_bytes(planWidth);
	assign planS = size_bytes(planSize);
	assign planN = (planS < planW) ? planS : planW; // [R8]
	assign planTbo = planAddr[1:0] + 2'(planK * planN);

	generate
		for (genvar gl = 0; gl < 4; gl++)
		begin : g_lane
			logic [2:0] om;
			logic [2:0] tbMod;
			logic [2:0] pos;
			logic [2:0] j;
			logic [2:0] sig;
			// offset served by this lane: [R9] [R10] [R11] [R12] [R13] [R14]
			assign om = planLittle ? 3'(gl) : 3'(planW - 3'h1 - 3'(gl)); // [R6]
			assign tbMod = {1'b0, planTbo} & (planW - 3'h1);
			assign pos = om - tbMod;
			assign next_laneValid[gl] = (3'(gl) < planW) && (om >= tbMod) && (pos < planN);
			assign j = 3'(planK * planN) + pos;
			assign sig = planLittle ? j : 3'(planS - 3'h1 - j); // [R6]
			assign next_laneSig[gl] = sig[1:0];
			assign next_laneData[gl*8 +: 8] = curReqData(sig[1:0]);
		end
	endgenerate

	function automatic logic [7:0] curReqData(input logic [1:0] idx);
		curReqData = (state == ST_IDLE) ? intReq.wdata[idx*8 +: 8] : curReq.wdata[idx*8 +: 8];
	endfunction

	// access sequencing
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state <= ST_IDLE;
			intReady <= 1'b0;
			intDone <= 1'b0;
			curReq <= '0;
			curWidth <= ebacc_pkg::CTRL_WIDTH_RESET;
			curType <= ebacc_pkg::CTRL_TYPE_RESET;
			curLittle <= 1'b0;
			xferIdx <= 2'h0;
			lastXfer <= 2'h0;
			waitCnt <= 8'h00;
		end
		else
		begin
			intDone <= 1'b0;
			unique case (state)
				ST_IDLE:
				begin
					if (accept)
					begin
						state <= ST_XFER;
						intReady <= 1'b0;
						curReq <= intReq;
						curWidth <= ctrlWidth;
						curType <= ctrlType;
						curLittle <= littleEndian;
						xferIdx <= 2'h0;
						lastXfer <= 2'(planS / planN - 3'h1); // [R8]
						waitCnt <= 8'h00;
					end
					else
						intReady <= strapTaken;
				end
				ST_XFER:
				begin
					if (waitCnt == 8'(ebacc_pkg::XFER_CYCLES - 1))
					begin
						waitCnt <= 8'h00;
						if (xferIdx == lastXfer)
							state <= ST_FINISH;
						else
							xferIdx <= xferIdx + 2'h1;
					end
					else
						waitCnt <= waitCnt + 8'h01;
				end
				ST_FINISH:
				begin
					state <= ST_IDLE;
					intDone <= 1'b1;
					intReady <= 1'b1;
				end
			endcase
		end
	end

	wire issue = accept || (state == ST_XFER && waitCnt == 8'(ebacc_pkg::XFER_CYCLES - 1) && xferIdx != lastXfer);
	wire release_bus = state == ST_FINISH;
	wire [31:0] planTransferAddr = {planAddr[31:2], planTbo};
	wire planWrite = (state == ST_IDLE) ? intReq.write : curReq.write;
	wire [1:0] planType = (state == ST_IDLE) ? ctrlType : curType;

	// external pins
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			extBus <= '0;
			laneWriteStrobeN <= 4'hF;
			laneColumnStrobeN <= 4'hF;
			laneDataMask <= 4'hF;
			laneValidQ <= 4'h0;
			for (int i = 0; i < 4; i++)
				laneSigQ[i] <= 2'h0;
		end
		else if (issue)
		begin
			extBus.addr <= planTransferAddr;
			extBus.data <= next_laneData;
			extBus.dataOe <= planWrite;
			extBus.write <= planWrite;
			extBus.active <= 1'b1;
			laneValidQ <= next_laneValid;
			for (int i = 0; i < 4; i++)
				laneSigQ[i] <= next_laneSig[i];
			// strobe role by memory type [R15]
			laneWriteStrobeN <= ((planType == ebacc_pkg::MEM_ORDINARY || planType == ebacc_pkg::MEM_CARD) && planWrite) ?
				~next_laneValid : 4'hF;
			laneColumnStrobeN <= (planType == ebacc_pkg::MEM_DRAM) ? ~next_laneValid : 4'hF;
			laneDataMask <= (planType == ebacc_pkg::MEM_SDRAM) ? ~next_laneValid : 4'hF;
		end
		else if (release_bus)
		begin
			extBus.dataOe <= 1'b0;
			extBus.active <= 1'b0;
			laneWriteStrobeN <= 4'hF; // [R15]
			laneColumnStrobeN <= 4'hF;
			laneDataMask <= 4'hF;
			laneValidQ <= 4'h0;
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			memoryChipSelectOutN <= {NUM_SELECTS{1'b1}};
		else if (accept)
			memoryChipSelectOutN <= next_selN; // [R4]
		else if (release_bus)
			memoryChipSelectOutN <= {NUM_SELECTS{1'b1}};
	end

	// read reassembly, one datum byte per slice
	wire capture = state == ST_XFER && waitCnt == 8'(ebacc_pkg::XFER_CYCLES - 1) && !curReq.write;

	generate
		for (genvar gb = 0; gb < 4; gb++)
		begin : g_asm
			always_ff @(posedge clk or negedge resetn)
			begin
				if (!resetn)
					rdAsm[gb] <= 8'h00;
				else if (accept)
					rdAsm[gb] <= 8'h00;
				else if (capture)
				begin
					for (int l = 0; l < 4; l++)
						if (laneValidQ[l] && laneSigQ[l] == 2'(gb))
							rdAsm[gb] <= dinSync[l*8 +: 8]; // [R16]
				end
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			intRData <= 32'h00000000;
		else if (state == ST_FINISH)
			intRData <= {rdAsm[3], rdAsm[2], rdAsm[1], rdAsm[0]}; // [R16]
	end

endmodule

//--- ebacc_core_chk.sv
// concurrent checks on the ports of the alignment and chip-select block
// assumes one clock domain, resetn asynchronous active low
module ebacc_core_chk #(
	parameter int NUM_SELECTS = 8
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] avAddress,
	input wire logic avRead,
	input wire logic avWrite,
	input wire logic [31:0] avWritedata,
	input wire logic [3:0] avByteenable,
	input wire logic [31:0] avReaddata,
	input wire logic avWaitrequest,
	input wire logic intValid,
	input wire ebacc_pkg::ebacc_req_t intReq,
	input wire logic intReady,
	input wire logic intDone,
	input wire logic [31:0] intRData,
	input wire logic byteOrderStrap,
	input wire ebacc_pkg::ebacc_ext_t extBus,
	input wire logic [31:0] extDataIn,
	input wire logic [3:0] laneWriteStrobeN,
	input wire logic [3:0] laneColumnStrobeN,
	input wire logic [3:0] laneDataMask,
	input wire logic [NUM_SELECTS-1:0] memoryChipSelectOutN
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	sequence s_take;
		intValid && intReady;
	endsequence
	sequence s_byte_take;
		s_take ##0 intReq.size == ebacc_pkg::SIZE_BYTE;
	endsequence
	sequence s_one_low;
		!avWaitrequest ##1 avWaitrequest;
	endsequence
	a_wait_one: assert property ((avRead || avWrite) && avWaitrequest |=> s_one_low)
		else $error("register answer not one cycle");
	a_done_pulse: assert property (intDone |=> !intDone)
		else $error("done longer than one cycle");
	a_busy_ready: assert property (s_take |=> !intReady)
		else $error("ready while busy");
	a_done_late: assert property (s_byte_take |-> ##[4:6] intDone)
		else $error("byte access not done in time");
	a_active_on: assert property (s_take |=> extBus.active)
		else $error("access not active after accept");
	a_cs_held: assert property (extBus.active && !$past(intValid && intReady) |-> $stable(memoryChipSelectOutN))
		else $error("chip select moved in access");
	a_idle_quiet: assert property (!extBus.active |-> &{laneWriteStrobeN, laneColumnStrobeN, laneDataMask})
		else $error("strobe asserted while idle");
	a_rd_no_we: assert property (extBus.active && !extBus.write |-> laneWriteStrobeN == 4'hF)
		else $error("write strobe during read");
	a_oe_write: assert property (extBus.active |-> extBus.dataOe == extBus.write)
		else $error("data drive does not follow direction");
	a_xfer_hold: assert property (extBus.active && $changed(extBus.addr) |=> $stable(extBus.addr) [*2])
		else $error("transfer shorter than three cycles");
endmodule
bind ebacc_core ebacc_core_chk #(.NUM_SELECTS(NUM_SELECTS)) u_chk (.clk(clk), .resetn(resetn),
	.avAddress(avAddress), .avRead(avRead), .avWrite(avWrite), .avWritedata(avWritedata),
	.avByteenable(avByteenable), .avReaddata(avReaddata), .avWaitrequest(avWaitrequest),
	.intValid(intValid), .intReq(intReq), .intReady(intReady), .intDone(intDone), .intRData(intRData),
	.byteOrderStrap(byteOrderStrap), .extBus(extBus), .extDataIn(extDataIn),
	.laneWriteStrobeN(laneWriteStrobeN), .laneColumnStrobeN(laneColumnStrobeN),
	.laneDataMask(laneDataMask), .memoryChipSelectOutN(memoryChipSelectOutN));

//--- ebacc_mem.sv
// partner model: external memory, one 32-bit word per bus address
// assumes active-low lane strobes and registered block outputs
module ebacc_mem (
	input wire logic clk,
	input wire ebacc_pkg::ebacc_ext_t extBus,
	input wire logic [3:0] wrN,
	input wire logic [3:0] colN,
	input wire logic [3:0] dqm,
	output logic [31:0] extDataIn
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] store [0:255];
	logic [31:0] last;
	logic [3:0] lanesOn;
	logic rd;
	assign lanesOn = ~wrN | ~colN | ~dqm;
	assign rd = extBus.active && !extBus.write;
	// released bus shows the inverse of the last value
	assign extDataIn = rd ? store[extBus.addr[7:0]] : ~last;
	initial
	begin
		for (int i = 0; i < 256; i++)
			store[i] = 32'h0;
		last = 32'h0;
	end
	always @(posedge clk)
	begin
		last <= extDataIn;
		if (extBus.active && extBus.write)
			for (int k = 0; k < 4; k++)
				if (lanesOn[k])
					store[extBus.addr[7:0]][k*8 +: 8] <= extBus.data[k*8 +: 8];
	end
endmodule

//--- ebacc_pkg.sv
// constants and carrier types for the external bus alignment and chip-select block
// assumes a single 20 MHz clock and a 32-bit register bus with byte addresses
package ebacc_pkg;

	localparam int NUM_SELECTS = 8;
	localparam int CLK_MHZ = 20;

	// register map, byte addresses
	localparam logic [7:0] CFG_BASE_ADDR = 8'h00;
	localparam logic [7:0] CTRL_ADDR = 8'h20;
	localparam logic [7:0] STATUS_ADDR = 8'h24;

	// chip-select configuration fields
	localparam int CFG_WIDTH = 7;
	localparam int CFG_AREA_BIT = 6;
	localparam int CFG_DENS_LO = 4;
	localparam int CFG_START_LO = 0;
	localparam logic [CFG_WIDTH-1:0] CFG_RESET = 7'h00;

	// control fields
	localparam int CTRL_WIDTH_LO = 0;
	localparam int CTRL_TYPE_LO = 2;
	localparam logic [1:0] WID_8 = 2'h0;
	localparam logic [1:0] WID_16 = 2'h1;
	localparam logic [1:0] WID_32 = 2'h2;
	localparam logic [1:0] MEM_ORDINARY = 2'h0;
	localparam logic [1:0] MEM_DRAM = 2'h1;
	localparam logic [1:0] MEM_SDRAM = 2'h2;
	localparam logic [1:0] MEM_CARD = 2'h3;
	localparam logic [1:0] CTRL_WIDTH_RESET = WID_32;
	localparam logic [1:0] CTRL_TYPE_RESET = MEM_ORDINARY;

	// status fields
	localparam int STAT_LITTLE_BIT = 0;
	localparam int STAT_STRAP_BIT = 1;
	localparam int STAT_BUSY_BIT = 2;

	// internal access sizes
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_WORD = 2'h1;
	localparam logic [1:0] SIZE_LONG = 2'h2;

	// address decode
	localparam logic [2:0] AREA_0 = 3'h0;
	localparam logic [2:0] AREA_2 = 3'h2;

	// timing
	localparam int XFER_NS = 150;
	localparam int XFER_CYCLES = (XFER_NS * CLK_MHZ + 999) / 1000;
	localparam logic [1:0] STRAP_SETTLE = 2'h3;

	typedef struct packed {
		logic [31:0] addr;
		logic [1:0] size;
		logic write;
		logic [31:0] wdata;
	} ebacc_req_t;

	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] data;
		logic dataOe;
		logic write;
		logic active;
	} ebacc_ext_t;

endpackage

//--- tb.sv
// self-checking bench for the alignment and chip-select block
// assumes the memory model on the external pins and a 20 MHz clock
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [1:0] SB = ebacc_pkg::SIZE_BYTE;
	localparam logic [1:0] SW = ebacc_pkg::SIZE_WORD;
	localparam logic [1:0] SL = ebacc_pkg::SIZE_LONG;
	localparam logic [7:0] CA = ebacc_pkg::CTRL_ADDR;
	localparam logic [15:0] LEGAL = 16'h3467;
	logic clk, resetn, avRead, avWrite, intValid, byteOrderStrap, intReady, intDone, avWaitrequest;
	logic [7:0] avAddress, csN, sCs;
	logic [31:0] avWritedata, avReaddata, intRData, extDataIn, q, e, rdat;
	logic [3:0] avByteenable, wrN, colN, dqm, sWr, sCol, sDqm;
	ebacc_pkg::ebacc_req_t intReq;
	ebacc_pkg::ebacc_ext_t extBus;
	int n_errors, samples_checked;
	ebacc_core DUT (.clk(clk), .resetn(resetn), .avAddress(avAddress), .avRead(avRead), .avWrite(avWrite),
		.avWritedata(avWritedata), .avByteenable(avByteenable), .avReaddata(avReaddata),
		.avWaitrequest(avWaitrequest), .intValid(intValid), .intReq(intReq), .intReady(intReady),
		.intDone(intDone), .intRData(intRData), .byteOrderStrap(byteOrderStrap), .extBus(extBus),
		.extDataIn(extDataIn), .laneWriteStrobeN(wrN), .laneColumnStrobeN(colN), .laneDataMask(dqm),
		.memoryChipSelectOutN(csN));
	ebacc_mem mem (.clk(clk), .extBus(extBus), .wrN(wrN), .colN(colN), .dqm(dqm), .extDataIn(extDataIn));
	initial
	begin
		clk = 0;
		forever #25 clk = ~clk;
	end
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out;
		if (n_errors == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic av(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		avWrite <= w;
		avRead <= !w;
		avAddress <= a;
		avWritedata <= d;
		@(posedge clk);
		while (avWaitrequest !== 1'b0 && n < 99)
		begin
			@(posedge clk);
			n++;
		end
		q = avReaddata;
		avWrite <= 0;
		avRead <= 0;
		if (n >= 99)
			n_errors++;
	endtask
	task automatic acc(input logic [31:0] a, input logic [1:0] sz, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		intValid <= 1;
		intReq <= '{addr: a, size: sz, write: w, wdata: d};
		@(posedge clk);
		while (intReady !== 1'b1 && n < 99)
		begin
			@(posedge clk);
			n++;
		end
		intValid <= 0;
		@(posedge clk);
		sCs = csN;
		sWr = wrN;
		sCol = colN;
		sDqm = dqm;
		while (intDone !== 1'b1 && n < 99)
		begin
			@(posedge clk);
			n++;
		end
		rdat = intRData;
		if (n >= 99)
			n_errors++;
	endtask
	task automatic rst(input logic strap);
		@(posedge clk);
		resetn <= 0;
		byteOrderStrap <= strap;
		repeat (16) @(posedge clk);
		resetn <= 1;
		// strap is taken at the third edge after release
		repeat (4) @(posedge clk);
	endtask
	task automatic t_regs;
		for (int i = 0; i < 8; i++)
		begin
			av(0, 8'(4*i), 32'h0);
			chk("cfg reset", q, 32'h0);
			av(1, 8'(4*i), 32'hF0 + 32'(i));
			av(0, 8'(4*i), 32'h0);
			chk("cfg rw", q, 32'h70 + 32'(i));
		end
		av(0, 8'h30, 32'h0);
		chk("unmapped", q, 32'h0);
		e = 32'h2;
		for (int v = 0; v < 16; v++)
		begin
			av(1, CA, 32'(v));
			if (LEGAL[v])
				e = 32'(v);
			av(0, CA, 32'h0);
			chk("ctrl", q, e);
		end
		av(1, CA, 32'h2);
	endtask
	task automatic t_cs;
		av(1, 8'h00, 32'h01);
		av(1, 8'h04, 32'h41);
		av(1, 8'h08, 32'h31);
		acc(32'h0040_0000, SB, 0, 0);
		chk("cs area0", 32'(sCs), 32'hFA);
		acc(32'h0840_0000, SB, 0, 0);
		chk("cs area2", 32'(sCs), 32'hFD);
		acc(32'h0200_0000, SB, 0, 0);
		chk("cs top", 32'(sCs), 32'hFB);
		acc(32'h0240_0000, SB, 0, 0);
		chk("cs past", 32'(sCs), 32'hFF);
	endtask
	task automatic t_be;
		acc(32'h10, SL, 1, 32'h1122_3344);
		chk("be32 long", mem.store[8'h10], 32'h1122_3344);
		acc(32'h11, SB, 1, 32'hAB);
		chk("be32 strobe", 32'(sWr), 32'hB);
		chk("be32 byte", 32'(mem.store[8'h11][23:16]), 32'hAB);
		mem.store[8'h12] = 32'h7777_5566;
		acc(32'h12, SW, 0, 0);
		chk("be32 word", rdat, 32'h5566);
		av(1, CA, 32'h1);
		mem.store[8'h20] = 32'hEEEE_1234;
		mem.store[8'h22] = 32'hEEEE_5678;
		acc(32'h20, SL, 0, 0);
		chk("be16 long", rdat, 32'h1234_5678);
		acc(32'h25, SB, 1, 32'hCD);
		chk("be16 strobe", 32'(sWr), 32'hE);
		av(1, CA, 32'h0);
		acc(32'h30, SL, 1, 32'hA1B2_C3D4);
		chk("be8 first", 32'(mem.store[8'h30][7:0]), 32'hA1);
		chk("be8 last", 32'(mem.store[8'h33][7:0]), 32'hD4);
		mem.store[8'h40] = 32'h0000_009A;
		mem.store[8'h41] = 32'h0000_00BC;
		acc(32'h40, SW, 0, 0);
		chk("be8 word", rdat, 32'h9ABC);
	endtask
	task automatic t_le;
		av(0, ebacc_pkg::STATUS_ADDR, 32'h0);
		chk("little", 32'(q[0]), 32'h1);
		acc(32'h51, SB, 1, 32'hEE);
		chk("le32 strobe", 32'(sWr), 32'hD);
		chk("le32 byte", 32'(mem.store[8'h51][15:8]), 32'hEE);
		acc(32'h52, SW, 1, 32'h7788);
		chk("le32 word", 32'(mem.store[8'h52][31:16]), 32'h7788);
		av(1, CA, 32'h1);
		mem.store[8'h60] = 32'hEEEE_5678;
		mem.store[8'h62] = 32'hEEEE_1234;
		acc(32'h60, SL, 0, 0);
		chk("le16 long", rdat, 32'h1234_5678);
		av(1, CA, 32'h0);
		for (int i = 0; i < 4; i++)
			mem.store[8'h70 + 8'(i)] = 32'hFFFF_FF44 - 32'(i * 'h11);
		acc(32'h70, SL, 0, 0);
		chk("le8 long", rdat, 32'h1122_3344);
		acc(32'h74, SW, 1, 32'hBEEF);
		chk("le8 first", 32'(mem.store[8'h74][7:0]), 32'hEF);
		chk("le8 second", 32'(mem.store[8'h75][7:0]), 32'hBE);
		av(1, CA, 32'h6);
		acc(32'h80, SW, 1, 32'h1357);
		chk("dram cas", 32'({sWr, sCol}), 32'hFC);
		av(1, CA, 32'hD);
		acc(32'h91, SB, 1, 32'h5A);
		chk("card strobe", 32'(sWr), 32'hD);
		chk("card byte", 32'(mem.store[8'h91][15:8]), 32'h5A);
		av(1, CA, 32'hA);
		mem.store[8'h83] = 32'h9A00_0000;
		acc(32'h83, SB, 0, 0);
		chk("sdram mask", 32'(sDqm), 32'h7);
		chk("sdram byte", rdat, 32'h9A);
	endtask
	initial
	begin
		#500000;
		n_errors++;
		close_out();
	end
	initial
	begin
		n_errors = 0;
		samples_checked = 0;
		resetn = 0;
		byteOrderStrap = 0;
		avRead = 0;
		avWrite = 0;
		avAddress = 8'h00;
		avWritedata = 32'h0;
		avByteenable = 4'hF;
		intValid = 0;
		intReq = '0;
		rst(0);
		t_regs();
		t_cs();
		t_be();
		rst(1);
		t_le();
		close_out();
	end
endmodule
